// ==== rtl/dig_pkg.sv ====
// Constants for the draw index generator: register map, command codes, field layout, resets.
//
// Notes on behaviour
// [R1] Sequential draw emits first upward, count indices.
// [R2] Disabled arrays take the current attribute value.
// [R3] Current values of enabled arrays become undefined.
// [R4] Negative first flags a bad argument.
// [R5] Multi-range draws ranges in order, skipping empties.
// [R6] Indexed draw reads count indices from buffer.
// [R7] Only unsigned 8, 16, 32-bit index types.
// [R8] Multi-list draws lists in order, skipping empties.
// [R9] Bounded draw with upper below lower: error.
// [R10] Out-of-bounds indices are not checked.
// [R11] Span and count hints are published, readable.
// [R12] Repetition counter is zero outside repetition.
// [R13] Repeated sequential: counter equals pass number.
// [R14] Repeated indexed: counter equals pass number.
// [R15] Invalid mode, count or type: no passes.
// [R16] Bias added as 32-bit unsigned with wrap.
// [R17] Negative biased index is flagged undefined.
// [R18] Bounds apply to raw index before bias.
// [R19] Reset: arrays disabled, float, four, restart zero.
// [R20] Allocate returns unused names, marks them used.
// [R21] Release frees names; zero or unused ignored. The code still pulses o_drop for an unused nonzero name in the pool.
// [R22] Restart index ends primitive, emits no vertex.
// [R23] Restart compare uses raw index before bias.
// [R24] Indices leave by valid and ready handshake.
package dig_pkg;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_FIRST = 8'h08;
	localparam logic [7:0] A_COUNT = 8'h0C;
	localparam logic [7:0] A_BIAS = 8'h10;
	localparam logic [7:0] A_ENT_SEL = 8'h14;
	localparam logic [7:0] A_REPEAT = 8'h18;
	localparam logic [7:0] A_LO = 8'h1C;
	localparam logic [7:0] A_HI = 8'h20;
	localparam logic [7:0] A_RESTART = 8'h24;
	localparam logic [7:0] A_CTRL = 8'h28;
	localparam logic [7:0] A_IDX_BASE = 8'h2C;
	localparam logic [7:0] A_ATTR_SEL = 8'h30;
	localparam logic [7:0] A_ATTR_BASE = 8'h34;
	localparam logic [7:0] A_ATTR_FMT = 8'h38;
	localparam logic [7:0] A_REP = 8'h3C;
	localparam logic [7:0] A_SPAN_HINT = 8'h40;
	localparam logic [7:0] A_CNT_HINT = 8'h44;
	localparam logic [7:0] A_ALLOC = 8'h48;
	localparam logic [7:0] A_RELEASE = 8'h4C;
	// Command word: kind [2:0], bias flag [3], primitive mode [6:4], index type [9:8].
	localparam logic [2:0] K_SEQ = 3'h0;
	localparam logic [2:0] K_MRANGE = 3'h1;
	localparam logic [2:0] K_IDX = 3'h2;
	localparam logic [2:0] K_MLIST = 3'h3;
	localparam logic [2:0] K_BOUND = 3'h4;
	localparam logic [2:0] K_RSEQ = 3'h5;
	localparam logic [2:0] K_RIDX = 3'h6;
	localparam int CMD_BIAS = 3;
	localparam int CMD_MODE_LSB = 4;
	localparam int CMD_TYPE_LSB = 8;
	localparam logic [2:0] MODE_MAX = 3'h6;
	localparam logic [1:0] T_U8 = 2'h0;
	localparam logic [1:0] T_U16 = 2'h1;
	localparam logic [1:0] T_U32 = 2'h2;
	// Status bits; error bits are cleared by writing one.
	localparam int ST_BUSY = 0;
	localparam int ST_ERR_ARG = 1;
	localparam int ST_ERR_ENUM = 2;
	localparam int ST_NONE_FREE = 3;
	localparam int CTRL_RESTART_EN = 0;
	// Attribute format word: stride [15:0], type [18:16], size [21:19], norm 22, int 23, en 24.
	localparam int F_TYPE_LSB = 16;
	localparam int F_SIZE_LSB = 19;
	localparam int F_NORM = 22;
	localparam int F_PINT = 23;
	localparam int F_EN = 24;
	localparam logic [2:0] FMT_FLOAT = 3'h6;
	localparam logic [2:0] FMT_SIZE_RST = 3'h4;
	localparam logic [31:0] RESTART_RST = 32'h0000_0000;
endpackage

// ==== rtl/dig_names.sv ====
// Buffer name pool: hands out the lowest unused name and takes names back.
`timescale 1ns/1ps
`default_nettype none
module dig_names #(
	parameter int NNAMES = 16,
	parameter int NW = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Requests
	input wire logic i_alloc,
	input wire logic i_release,
	input wire logic [NW-1:0] i_name,
	// Answers
	output logic [NW-1:0] o_free,
	output logic o_none
);
	logic [NNAMES-1:0] used;

	// Name zero is never handed out, so the search starts at one.
	always_comb begin
		o_free = '0;
		o_none = 1'b1;
		for (int k = NNAMES - 1; k >= 1; k--) begin
			if (!used[k]) begin
				o_free = NW'(k);
				o_none = 1'b0;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NNAMES; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					used[g] <= 1'b0;
				end else if (i_alloc && !o_none && o_free == NW'(g)) begin
					used[g] <= 1'b1; // [R20]
				end else if (i_release && i_name == NW'(g) && g != 0) begin
					used[g] <= 1'b0; // [R21]
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== rtl/dig_core.sv ====
// Draw index generator: register port, draw sequencer, index fetch and output handshake.
`timescale 1ns/1ps
`default_nettype none
module dig_core #(
	parameter int NATTR = 4,
	parameter int NENT = 4,
	parameter int NNAMES = 16,
	parameter logic [31:0] SPAN_HINT = 32'h0000_1000,
	parameter logic [31:0] CNT_HINT = 32'h0000_1000
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Index buffer read port
	output logic o_mem_req,
	output logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic [31:0] i_mem_data,
	// Vertex stream to attribute fetch
	output logic o_vld,
	input wire logic i_rdy,
	output logic [31:0] o_index,
	output logic [31:0] o_rep,
	output logic o_undef,
	output logic o_cut,
	output logic [NATTR-1:0] o_attr_fetch,
	output logic [NATTR-1:0] o_attr_current,
	// Released buffer notice
	output logic o_drop,
	output logic [31:0] o_drop_name
);
	localparam int NW = $clog2(NNAMES);
	localparam int EW = $clog2(NENT);
	localparam int AW = $clog2(NATTR);

	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ENTRY, S_ELEM, S_FETCH, S_WAIT, S_EMIT}
		dig_state_t;

	////////////////////////////////////////////////////////////////////////////////
	logic rst_q1;
	logic rst_n;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	dig_state_t state;
	logic [9:0] cmd;
	logic [EW-1:0] ent_sel;
	logic [31:0] ent_first [NENT];
	logic [31:0] ent_count [NENT];
	logic [31:0] ent_bias [NENT];
	logic [31:0] repeat_n, lo, hi, restart_val, idx_base, ctrl;
	logic [AW-1:0] attr_sel;
	logic [NATTR-1:0] a_en, a_norm, a_pint;
	logic [31:0] a_base [NATTR];
	logic [15:0] a_stride [NATTR];
	logic [2:0] a_type [NATTR];
	logic [2:0] a_size [NATTR];
	logic err_arg, err_enum;
	logic [NW-1:0] free_name;
	logic none_free;
	logic wr_ok;
	logic alloc_rd;
	logic rel_wr;

	assign wr_ok = i_wr && state == S_IDLE;
	assign alloc_rd = i_rd && i_addr == dig_pkg::A_ALLOC;
	assign rel_wr = i_wr && i_addr == dig_pkg::A_RELEASE;

	// Draw parameters are frozen while a draw runs so a pass can be replayed.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ent_sel <= '0;
			repeat_n <= 32'h0000_0000;
			lo <= 32'h0000_0000;
			hi <= 32'h0000_0000;
			restart_val <= dig_pkg::RESTART_RST; // [R19]
			idx_base <= 32'h0000_0000;
			ctrl <= 32'h0000_0000;
		end else if (wr_ok) begin
			if (i_addr == dig_pkg::A_ENT_SEL) begin
				ent_sel <= i_wdata[EW-1:0];
			end else if (i_addr == dig_pkg::A_REPEAT) begin
				repeat_n <= i_wdata;
			end else if (i_addr == dig_pkg::A_LO) begin
				lo <= i_wdata;
			end else if (i_addr == dig_pkg::A_HI) begin
				hi <= i_wdata;
			end else if (i_addr == dig_pkg::A_RESTART) begin
				restart_val <= i_wdata;
			end else if (i_addr == dig_pkg::A_IDX_BASE) begin
				idx_base <= i_wdata;
			end else if (i_addr == dig_pkg::A_CTRL) begin
				ctrl <= i_wdata;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NENT; g++) begin : g_ent
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					ent_first[g] <= 32'h0000_0000;
					ent_count[g] <= 32'h0000_0000;
					ent_bias[g] <= 32'h0000_0000;
				end else if (wr_ok && ent_sel == EW'(g)) begin
					if (i_addr == dig_pkg::A_FIRST) begin
						ent_first[g] <= i_wdata;
					end else if (i_addr == dig_pkg::A_COUNT) begin
						ent_count[g] <= i_wdata;
					end else if (i_addr == dig_pkg::A_BIAS) begin
						ent_bias[g] <= i_wdata;
					end
				end
			end
		end
		for (g = 0; g < NATTR; g++) begin : g_attr
			always_ff @(posedge i_clk or negedge rst_n) begin
				if (!rst_n) begin
					a_en[g] <= 1'b0; // [R19]
					a_base[g] <= 32'h0000_0000;
					a_stride[g] <= 16'h0000;
					a_type[g] <= dig_pkg::FMT_FLOAT;
					a_size[g] <= dig_pkg::FMT_SIZE_RST;
					a_norm[g] <= 1'b0;
					a_pint[g] <= 1'b0;
				end else if (wr_ok && attr_sel == AW'(g)) begin
					if (i_addr == dig_pkg::A_ATTR_BASE) begin
						a_base[g] <= i_wdata;
					end else if (i_addr == dig_pkg::A_ATTR_FMT) begin
						a_stride[g] <= i_wdata[15:0];
						a_type[g] <= i_wdata[dig_pkg::F_TYPE_LSB +: 3];
						a_size[g] <= i_wdata[dig_pkg::F_SIZE_LSB +: 3];
						a_norm[g] <= i_wdata[dig_pkg::F_NORM];
						a_pint[g] <= i_wdata[dig_pkg::F_PINT];
						a_en[g] <= i_wdata[dig_pkg::F_EN];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			attr_sel <= '0;
		end else if (wr_ok && i_addr == dig_pkg::A_ATTR_SEL) begin
			attr_sel <= i_wdata[AW-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	dig_names #(.NNAMES(NNAMES), .NW(NW)) u_names (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_alloc(alloc_rd),
		.i_release(rel_wr && i_wdata < 32'(NNAMES)), // [R21]
		.i_name(i_wdata[NW-1:0]),
		.o_free(free_name),
		.o_none(none_free)
	);

	// A release tells the store to drop the contents; zero and out-of-pool names are ignored.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_drop <= 1'b0;
			o_drop_name <= 32'h0000_0000;
		end else begin
			o_drop <= rel_wr && i_wdata != 32'h0000_0000 && i_wdata < 32'(NNAMES); // [R21]
			o_drop_name <= i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] itype;
	logic [2:0] kind;
	logic indexed, multi, inst, use_bias;
	logic [31:0] passes, pass_no, elem, cur_first, cur_count, cur_bias, mem_addr;
	logic [EW-1:0] ent_now;
	logic [31:0] raw;
	logic [32:0] biased;
	logic [2:0] isize;

	assign kind = cmd[2:0];
	assign itype = cmd[dig_pkg::CMD_TYPE_LSB +: 2];
	assign indexed = kind == dig_pkg::K_IDX || kind == dig_pkg::K_MLIST
		|| kind == dig_pkg::K_BOUND || kind == dig_pkg::K_RIDX;
	assign multi = kind == dig_pkg::K_MRANGE || kind == dig_pkg::K_MLIST;
	assign inst = kind == dig_pkg::K_RSEQ || kind == dig_pkg::K_RIDX;
	assign use_bias = cmd[dig_pkg::CMD_BIAS] && indexed;
	assign ent_now = multi ? pass_no[EW-1:0] : '0;
	assign isize = itype == dig_pkg::T_U8 ? 3'h1 : (itype == dig_pkg::T_U16 ? 3'h2 : 3'h4);

	// Unsigned index extraction from the word that holds the addressed byte.
	always_comb begin
		raw = i_mem_data; // [R7]
		if (itype == dig_pkg::T_U8) begin
			raw = {24'h00_0000, i_mem_data[8 * mem_addr[1:0] +: 8]};
		end else if (itype == dig_pkg::T_U16) begin
			raw = {16'h0000, i_mem_data[16 * mem_addr[1] +: 16]};
		end
	end

	// A 33rd bit flags a negative biased index, and also a sum that wraps past 32 bits with a positive bias.
	assign biased = {1'b0, raw} + {cur_bias[31], cur_bias}; // [R16]

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cmd <= 10'h000;
			passes <= 32'h0000_0000;
			pass_no <= 32'h0000_0000;
			elem <= 32'h0000_0000;
			cur_first <= 32'h0000_0000;
			cur_count <= 32'h0000_0000;
			cur_bias <= 32'h0000_0000;
			mem_addr <= 32'h0000_0000;
			o_mem_req <= 1'b0;
			o_mem_addr <= 32'h0000_0000;
			o_vld <= 1'b0;
			o_index <= 32'h0000_0000;
			o_rep <= 32'h0000_0000;
			o_undef <= 1'b0;
			o_cut <= 1'b0;
			o_attr_fetch <= '0;
			o_attr_current <= '0;
			err_arg <= 1'b0;
			err_enum <= 1'b0;
		end else begin
			o_cut <= 1'b0;
			if (i_wr && i_addr == dig_pkg::A_STATUS) begin
				err_arg <= err_arg & ~i_wdata[dig_pkg::ST_ERR_ARG];
				err_enum <= err_enum & ~i_wdata[dig_pkg::ST_ERR_ENUM];
			end
			case (state)
				S_IDLE: begin
					if (wr_ok && i_addr == dig_pkg::A_CMD) begin
						cmd <= i_wdata[9:0];
						state <= S_CHECK;
					end
				end
				S_CHECK: begin
					pass_no <= 32'h0000_0000;
					passes <= (multi || inst) ? repeat_n : 32'h0000_0001;
					// Sample array enables once per draw; disabled ones read current state.
					o_attr_fetch <= a_en; // [R3]
					o_attr_current <= ~a_en; // [R2]
					state <= S_ENTRY;
					if (cmd[dig_pkg::CMD_MODE_LSB +: 3] > dig_pkg::MODE_MAX
						|| (indexed && itype > dig_pkg::T_U32)) begin
						err_enum <= 1'b1; // [R15] [R7]
						state <= S_IDLE;
					end else if ((kind == dig_pkg::K_BOUND && hi < lo) // [R9]
						|| ((multi || inst) && repeat_n[31])
						|| (!multi && ent_count[0][31])
						|| (!indexed && !multi && ent_first[0][31])) begin
						err_arg <= 1'b1; // [R4] [R15]
						state <= S_IDLE;
					end
				end
				S_ENTRY: begin
					if (pass_no >= passes || passes[31]) begin
						o_rep <= 32'h0000_0000; // [R12] [R13] [R14]
						state <= S_IDLE;
					end else begin
						o_rep <= inst ? pass_no : 32'h0000_0000; // [R13] [R14]
						cur_first <= ent_first[ent_now];
						cur_count <= ent_count[ent_now];
						cur_bias <= use_bias ? ent_bias[ent_now] : 32'h0000_0000;
						elem <= 32'h0000_0000;
						state <= S_ELEM;
					end
				end
				S_ELEM: begin
					// A count of zero or below ends the range at once, so it is skipped.
					if ($signed(elem) >= $signed(cur_count)) begin // [R5] [R8]
						pass_no <= pass_no + 32'h0000_0001;
						state <= S_ENTRY;
					end else if (indexed) begin
						mem_addr <= idx_base + cur_first + elem * 32'(isize); // [R6]
						state <= S_FETCH;
					end else begin
						o_index <= cur_first + elem; // [R1]
						o_undef <= 1'b0;
						o_vld <= 1'b1;
						state <= S_EMIT;
					end
				end
				S_FETCH: begin
					o_mem_req <= 1'b1;
					o_mem_addr <= mem_addr;
					state <= S_WAIT;
				end
				S_WAIT: begin
					if (i_mem_ack) begin
						o_mem_req <= 1'b0;
						// Bounds are not checked; out-of-range indices pass as fetched.
						if (ctrl[dig_pkg::CTRL_RESTART_EN] && raw == restart_val) begin // [R23]
							o_cut <= 1'b1; // [R22] [R10] [R18]
							elem <= elem + 32'h0000_0001;
							state <= S_ELEM;
						end else begin
							o_index <= biased[31:0]; // [R16]
							o_undef <= biased[32]; // [R17]
							o_vld <= 1'b1;
							state <= S_EMIT;
						end
					end
				end
				S_EMIT: begin
					if (i_rdy) begin
						o_vld <= 1'b0; // [R24]
						o_undef <= 1'b0; // [R17]
						elem <= elem + 32'h0000_0001;
						state <= S_ELEM;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (!i_rd) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_addr == dig_pkg::A_CMD) begin
			o_rdata <= {22'h00_0000, cmd};
		end else if (i_addr == dig_pkg::A_STATUS) begin
			o_rdata <= {28'h000_0000, none_free, err_enum, err_arg, state != S_IDLE};
		end else if (i_addr == dig_pkg::A_FIRST) begin
			o_rdata <= ent_first[ent_sel];
		end else if (i_addr == dig_pkg::A_COUNT) begin
			o_rdata <= ent_count[ent_sel];
		end else if (i_addr == dig_pkg::A_BIAS) begin
			o_rdata <= ent_bias[ent_sel];
		end else if (i_addr == dig_pkg::A_ENT_SEL) begin
			o_rdata <= 32'(ent_sel);
		end else if (i_addr == dig_pkg::A_REPEAT) begin
			o_rdata <= repeat_n;
		end else if (i_addr == dig_pkg::A_LO) begin
			o_rdata <= lo;
		end else if (i_addr == dig_pkg::A_HI) begin
			o_rdata <= hi;
		end else if (i_addr == dig_pkg::A_RESTART) begin
			o_rdata <= restart_val;
		end else if (i_addr == dig_pkg::A_CTRL) begin
			o_rdata <= ctrl;
		end else if (i_addr == dig_pkg::A_IDX_BASE) begin
			o_rdata <= idx_base;
		end else if (i_addr == dig_pkg::A_ATTR_SEL) begin
			o_rdata <= 32'(attr_sel);
		end else if (i_addr == dig_pkg::A_ATTR_BASE) begin
			o_rdata <= a_base[attr_sel];
		end else if (i_addr == dig_pkg::A_ATTR_FMT) begin
			o_rdata <= {7'h00, a_en[attr_sel], a_pint[attr_sel], a_norm[attr_sel],
				a_size[attr_sel], a_type[attr_sel], a_stride[attr_sel]};
		end else if (i_addr == dig_pkg::A_REP) begin
			o_rdata <= o_rep; // [R12]
		end else if (i_addr == dig_pkg::A_SPAN_HINT) begin
			o_rdata <= SPAN_HINT; // [R11]
		end else if (i_addr == dig_pkg::A_CNT_HINT) begin
			o_rdata <= CNT_HINT; // [R11]
		end else if (i_addr == dig_pkg::A_ALLOC) begin
			o_rdata <= none_free ? 32'h0000_0000 : 32'(free_name); // [R20]
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ==== test/dig_mem_model.sv ====
// Behavioural index buffer memory seen by the draw index generator.
`timescale 1ns/1ps
`default_nettype none
module dig_mem_model (
	// Clock
	input wire logic i_clk,
	// Request from the block and answer delay
	input wire logic i_req,
	input wire logic [31:0] i_addr,
	input wire logic [3:0] i_wait,
	// Answer
	output logic o_ack,
	output logic [31:0] o_data
);
	logic [3:0] cnt = 4'h0;
	logic [5:0] w;
	assign w = i_addr[7:2];
	initial begin
		o_ack = 1'b0;
		o_data = 32'h0000_0000;
	end
	// Each byte holds the low byte of its own address. Outside an answer the data
	// toggle every cycle so that a stale capture cannot pass.
	always @(posedge i_clk) begin
		if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			o_data <= ~o_data;
			cnt <= 4'h0;
		end else if (cnt == i_wait) begin
			o_ack <= 1'b1;
			o_data <= {w, 2'h3, w, 2'h2, w, 2'h1, w, 2'h0};
		end else begin
			cnt <= cnt + 4'h1;
			o_data <= ~o_data;
		end
	end
endmodule
`default_nettype wire

// ==== test/dig_core_asserts.sv ====
// Port-level assertions for the draw index generator core.
`timescale 1ns/1ps
`default_nettype none
module dig_core_asserts #(
	parameter int NATTR = 4,
	parameter logic [31:0] SPAN_HINT = 32'h0000_1000,
	parameter logic [31:0] CNT_HINT = 32'h0000_1000
) (
	// Clock, reset and register port
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	// Index fetch, vertex stream and release notice
	input wire logic o_mem_req,
	input wire logic [31:0] o_mem_addr,
	input wire logic i_mem_ack,
	input wire logic o_vld,
	input wire logic i_rdy,
	input wire logic [31:0] o_index,
	input wire logic [31:0] o_rep,
	input wire logic o_undef,
	input wire logic o_cut,
	input wire logic [NATTR-1:0] o_attr_fetch,
	input wire logic [NATTR-1:0] o_attr_current,
	input wire logic o_drop,
	input wire logic [31:0] o_drop_name
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////////////
	vld_hold_a: assert property (o_vld && !i_rdy |=> o_vld && $stable(o_index) && $stable(o_rep))
		else $error("vertex changed before it was accepted");
	attr_split_a: assert property (o_vld |-> o_attr_current == ~o_attr_fetch)
		else $error("attribute source split is not complementary");
	cut_pulse_a: assert property (o_cut |=> !o_cut)
		else $error("restart cut longer than one cycle");
	undef_vld_a: assert property (o_undef |-> o_vld)
		else $error("undefined flag without a vertex");
	req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("index request dropped or moved before answer");
	drop_cause_a: assert property (o_drop |-> $past(i_wr) && $past(i_addr) == dig_pkg::A_RELEASE
		&& o_drop_name == $past(i_wdata) && o_drop_name != 32'h0000_0000)
		else $error("release notice without a matching release write");
	span_hint_a: assert property ($past(i_rd) && $past(i_addr) == dig_pkg::A_SPAN_HINT
		|-> o_rdata == SPAN_HINT)
		else $error("span hint reads wrong");
	cnt_hint_a: assert property ($past(i_rd) && $past(i_addr) == dig_pkg::A_CNT_HINT
		|-> o_rdata == CNT_HINT)
		else $error("count hint reads wrong");
endmodule
bind dig_core dig_core_asserts #(.NATTR(NATTR), .SPAN_HINT(SPAN_HINT), .CNT_HINT(CNT_HINT)) u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
	.i_mem_ack(i_mem_ack), .o_vld(o_vld), .i_rdy(i_rdy), .o_index(o_index), .o_rep(o_rep),
	.o_undef(o_undef), .o_cut(o_cut), .o_attr_fetch(o_attr_fetch),
	.o_attr_current(o_attr_current), .o_drop(o_drop), .o_drop_name(o_drop_name));
`default_nettype wire

// ==== test/draw_index_generator_tb.sv ====
// Self-checking bench for the draw index generator.
`timescale 1ns/1ps
`default_nettype none
module draw_index_generator_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rdy = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] mwait = 4'h0;
	logic ack, req, vld, undef, cut, drop;
	logic [31:0] rdata, maddr, mdata, index, rep, dname;
	logic [3:0] fetch, cur;
	int fails = 0;
	int total_checks = 0;
	int accepts = 0;
	int cuts = 0;
	int drops = 0;
	logic [31:0] fmt0;
	assign fmt0 = (32'(dig_pkg::FMT_SIZE_RST) << dig_pkg::F_SIZE_LSB)
		| (32'(dig_pkg::FMT_FLOAT) << dig_pkg::F_TYPE_LSB);
	dig_core uut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_mem_req(req), .o_mem_addr(maddr), .i_mem_ack(ack),
		.i_mem_data(mdata), .o_vld(vld), .i_rdy(rdy), .o_index(index), .o_rep(rep),
		.o_undef(undef), .o_cut(cut), .o_attr_fetch(fetch), .o_attr_current(cur),
		.o_drop(drop), .o_drop_name(dname));
	dig_mem_model mem (.i_clk(clk), .i_req(req), .i_addr(maddr), .i_wait(mwait),
		.o_ack(ack), .o_data(mdata));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (vld === 1'b1 && rdy === 1'b1) accepts++;
		if (cut === 1'b1) cuts++;
		if (drop === 1'b1) drops++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rdr(a, d);
		chk(d, exp);
	endtask
	task automatic idle;
		logic [31:0] s;
		for (int n = 0; n < 60; n++) begin
			rdr(dig_pkg::A_STATUS, s);
			if (s[dig_pkg::ST_BUSY] === 1'b0) break;
		end
	endtask
	task ent(input logic [31:0] e, input logic [31:0] f, input logic [31:0] c, input logic [31:0] b);
		wrr(dig_pkg::A_ENT_SEL, e);
		wrr(dig_pkg::A_FIRST, f);
		wrr(dig_pkg::A_COUNT, c);
		wrr(dig_pkg::A_BIAS, b);
	endtask
	// The stream side drops ready for one cycle after every accept, before the next vertex is raised, so no vertex is held.
	task automatic get(input logic [31:0] ei, input logic [31:0] er, input logic eu);
		int n = 0;
		@(posedge clk);
		rdy <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (!(vld === 1'b1 && rdy === 1'b1) && n < 300);
		chk(index, ei);
		chk(rep, er);
		chk(undef, eu);
		rdy <= 1'b0;
	endtask
	function automatic logic [31:0] ival(input logic [1:0] t, input logic [7:0] o);
		if (t == dig_pkg::T_U8) return {24'h0, o};
		if (t == dig_pkg::T_U16) return {16'h0, o + 8'h1, o};
		return {o + 8'h3, o + 8'h2, o + 8'h1, o};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		rchk(dig_pkg::A_REP, 32'h0);
		wrr(dig_pkg::A_ATTR_SEL, 32'h2);
		rchk(dig_pkg::A_ATTR_FMT, fmt0);
		rchk(dig_pkg::A_RESTART, dig_pkg::RESTART_RST);
		rchk(dig_pkg::A_SPAN_HINT, 32'h0000_1000);
		rchk(dig_pkg::A_CNT_HINT, 32'h0000_1000);
		rchk(8'hFC, 32'h0);
		$display("test regs done");
	endtask
	task t_seq;
		wrr(dig_pkg::A_ATTR_SEL, 32'h1);
		wrr(dig_pkg::A_ATTR_FMT, fmt0 | (32'h1 << dig_pkg::F_EN));
		ent(0, 5, 3, 0);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_SEQ));
		for (int i = 0; i < 3; i++) get(5 + i, 0, 0);
		chk(fetch, 4'h2);
		chk(cur, 4'hD);
		idle;
		ent(0, 2, 2, 0);
		ent(1, 7, 0, 0);
		ent(2, 9, 1, 0);
		wrr(dig_pkg::A_REPEAT, 3);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_MRANGE));
		get(2, 0, 0);
		get(3, 0, 0);
		get(9, 0, 0);
		idle;
		ent(0, 0, 2, 0);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_RSEQ));
		for (int r = 0; r < 3; r++) for (int i = 0; i < 2; i++) get(i, r, 0);
		idle;
		rchk(dig_pkg::A_REP, 32'h0);
		$display("test sequential done");
	endtask
	task automatic t_idx;
		logic [31:0] c;
		for (int t = 0; t < 3; t++) begin
			mwait <= 4'(t * 3);
			ent(0, 8'h40, 2, 0);
			wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_IDX) | (32'(t) << dig_pkg::CMD_TYPE_LSB));
			for (int i = 0; i < 2; i++) get(ival(2'(t), 8'(8'h40 + i * (1 << t))), 0, 0);
			idle;
		end
		ent(0, 8'h40, 1, 0);
		wrr(dig_pkg::A_REPEAT, 2);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_RIDX));
		get(8'h40, 0, 0);
		get(8'h40, 1, 0);
		idle;
		c = 32'(dig_pkg::K_MLIST) | (32'h1 << dig_pkg::CMD_BIAS);
		ent(1, 8'h48, 0, 0);
		ent(2, 8'h50, 1, 32'h100);
		wrr(dig_pkg::A_REPEAT, 3);
		wrr(dig_pkg::A_CMD, c);
		get(8'h40, 0, 0);
		get(32'h150, 0, 0);
		idle;
		ent(0, 8'h10, 2, 32'hFFFF_FFEF);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_IDX) | (32'h1 << dig_pkg::CMD_BIAS));
		get(32'hFFFF_FFFF, 0, 1);
		get(32'h0, 0, 0);
		idle;
		wrr(dig_pkg::A_RESTART, 8'h41);
		wrr(dig_pkg::A_CTRL, 32'h1);
		ent(0, 8'h40, 3, 32'h100);
		c = cuts;
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_IDX) | (32'h1 << dig_pkg::CMD_BIAS));
		get(32'h140, 0, 0);
		get(32'h142, 0, 0);
		idle;
		chk(cuts, c + 1);
		wrr(dig_pkg::A_CTRL, 32'h0);
		ent(0, 8'h40, 2, 32'h10);
		wrr(dig_pkg::A_LO, 32'h40);
		wrr(dig_pkg::A_HI, 32'h40);
		wrr(dig_pkg::A_CMD, 32'(dig_pkg::K_BOUND) | (32'h1 << dig_pkg::CMD_BIAS));
		get(32'h50, 0, 0);
		get(32'h51, 0, 0);
		idle;
		$display("test indexed done");
	endtask
	task automatic t_err;
		logic [31:0] c [4];
		int b [4];
		logic [31:0] s;
		int a0;
		c = '{32'(dig_pkg::K_BOUND), 32'(dig_pkg::K_RIDX) | 32'h70, 32'(dig_pkg::K_IDX) | 32'h300,
			32'(dig_pkg::K_SEQ)};
		b = '{dig_pkg::ST_ERR_ARG, dig_pkg::ST_ERR_ENUM, dig_pkg::ST_ERR_ENUM, dig_pkg::ST_ERR_ARG};
		wrr(dig_pkg::A_REPEAT, 1);
		wrr(dig_pkg::A_LO, 5);
		wrr(dig_pkg::A_HI, 4);
		rdy <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			ent(0, (i == 3) ? 32'hFFFF_FFFF : 32'h40, 2, 0);
			a0 = accepts;
			wrr(dig_pkg::A_CMD, c[i]);
			idle;
			rdr(dig_pkg::A_STATUS, s);
			chk(s[b[i]], 1'b1);
			chk(accepts, a0);
			wrr(dig_pkg::A_STATUS, 32'h6);
		end
		rdy <= 1'b0;
		$display("test errors done");
	endtask
	task t_names;
		rchk(dig_pkg::A_ALLOC, 1);
		rchk(dig_pkg::A_ALLOC, 2);
		wrr(dig_pkg::A_RELEASE, 1);
		repeat (2) @(posedge clk);
		chk(drops, 1);
		chk(dname, 1);
		rchk(dig_pkg::A_ALLOC, 1);
		wrr(dig_pkg::A_RELEASE, 0);
		repeat (2) @(posedge clk);
		chk(drops, 1);
		$display("test names done");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_seq;
		t_idx;
		t_err;
		t_names;
		give_verdict;
	end
	initial begin
		#1000000;
		fails++;
		give_verdict;
	end
endmodule
`default_nettype wire
